// file: src/iews_cfg.svh
`ifndef IEWS_CFG_SVH
`define IEWS_CFG_SVH
// device type code of the select byte; value is arbitrary
`define IEWS_DEV_TYPE 4'h6
// protection pointer location and its flag bit, which must be zero to protect
`define IEWS_PTR_ADDR 11'h7ff
`define IEWS_PTR_FLAG_BIT 2
// programming time in ms and the system clock rate in MHz
`define IEWS_PROG_TIME_MS 10
`define IEWS_CLK_MHZ 200
`define IEWS_PROG_CYC (`IEWS_PROG_TIME_MS * 1000 * `IEWS_CLK_MHZ)
// row, page and multibyte sizes
`define IEWS_ROW_BYTES 16
`define IEWS_MULTI_BYTES 8
// serial clock period in ns, quarter period in system cycles
`define IEWS_SCL_PERIOD_NS 10000
`define IEWS_CLK_PERIOD_NS 5
`define IEWS_QTR_CYC (`IEWS_SCL_PERIOD_NS / 4 / `IEWS_CLK_PERIOD_NS)
// controller register byte offsets
`define IEWS_REG_CMD 4'h0
`define IEWS_REG_STATUS 4'h4
// command word fields and op codes
`define IEWS_CMD_OP_LSB 8
`define IEWS_OP_START_BYTE 2'h1
`define IEWS_OP_BYTE 2'h2
`define IEWS_OP_STOP 2'h3
// status bits
`define IEWS_ST_BUSY 0
`define IEWS_ST_NACK 1
`endif

// file: src/iews_pkg.sv
package iews_pkg;
   typedef enum logic [2:0] {
      DS_IDLE = 3'b000,
      DS_DSEL = 3'b001,
      DS_ADDR = 3'b011,
      DS_DATA = 3'b010,
      DS_PROG = 3'b110,
      DS_READ = 3'b111
   } iews_dev_state_t;
   typedef enum logic [1:0] {
      MS_IDLE = 2'b00,
      MS_START = 2'b01,
      MS_BITS = 2'b11,
      MS_STOP = 2'b10
   } iews_mst_state_t;
endpackage

// file: src/iews_if.sv
interface iews_if;
   // serial clock, driven by the controller only
   logic scl_out;
   logic scl_oe_n;
   // data line drivers of both ends
   logic m_sda_out;
   logic m_sda_oe_n;
   logic d_sda_out;
   logic d_sda_oe_n;
   // resolved lines with pull-ups
   logic scl;
   logic sda;
   assign scl = scl_oe_n | scl_out;
   assign sda = (m_sda_oe_n | m_sda_out) & (d_sda_oe_n | d_sda_out);
   modport mst (
      output scl_out, scl_oe_n, m_sda_out, m_sda_oe_n,
      input sda
   );
   modport dev (
      output d_sda_out, d_sda_oe_n,
      input scl, sda
   );
endinterface

// file: src/iews_dev.sv
// Functional notes
// - start is data falling while clock high
// - watch for start except while programming
// - stop is data rising while clock high
// - stop after read returns to standby
// - stop after write launches programming
// - release data after 8 bits, ack 9th
// - sample data on rising serial clock
// - select byte: type, block, direction
// - ack select, take and ack byte address
// - mode pin high multibyte, low page
// - inhibit pin high: no write, no ack
// - byte write works in any mode
// - multibyte accepts one to eight bytes; this model latches up to sixteen
// - program 10ms, 20ms across two rows
// - master writes at most eight multibyte
// - page write wraps low four address bits
// - ignore everything until programming ends
// - poll with select, ack when ready
// - pointer upper nibble sets boundary row
// - block select pins pick blocks 4 to 7
// - protect only with enable high, flag zero
// - multibyte may overrun seven protected bytes
//
// Design decision made here: the Avalon-MM interface to the registers.
`include "iews_cfg.svh"
module iews_dev
   import iews_pkg::*;
#(
   parameter int PROG_CYC = `IEWS_PROG_CYC,
   parameter bit WC_VARIANT = 1'b0
) (
   // system
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   // serial link
   iews_if.dev LINK,
   // strap pins
   input wire logic I_MODE_MULTI,
   input wire logic I_WRITE_INHIBIT_PIN,
   input wire logic I_PROTECT_EN,
   input wire logic I_PROTECT_BLOCK_SEL_LO,
   input wire logic I_PROTECT_BLOCK_SEL_HI,
   // status
   output logic O_BUSY
);

   ////////////////////////////////////////////////////////////////////////////
   logic [6:0] meta_q;
   logic [6:0] sync_q;
   logic scl_d1_q;
   logic sda_d1_q;
   logic [7:0] mem [0:2047];
   logic [7:0] buf_data [0:15];
   logic [10:0] buf_addr [0:15];
   iews_dev_state_t state_q;
   logic [3:0] bcnt_q;
   logic rose_q;
   logic [7:0] shift_q;
   logic sda_oe_n_q;
   logic inhibit_q;
   logic multi_q;
   logic [10:0] ptr_q;
   logic [4:0] count_q;
   logic [10:0] last_q;
   logic [4:0] pidx_q;
   logic [22:0] timer_q;
   logic busy_q;

   wire scl_s = sync_q[6];
   wire sda_s = sync_q[5];
   wire mode_s = sync_q[4];
   wire wc_s = sync_q[3] & WC_VARIANT;
   wire pre_s = sync_q[2];
   wire [1:0] pb_s = sync_q[1:0];
   wire active = state_q != DS_PROG;
   wire start_ev = active & scl_s & scl_d1_q & sda_d1_q & ~sda_s;
   wire stop_ev = active & scl_s & scl_d1_q & ~sda_d1_q & sda_s;
   wire rise_ev = active & scl_s & ~scl_d1_q;
   wire fall_ev = active & ~scl_s & scl_d1_q & rose_q;
   wire byte_end = fall_ev & (bcnt_q == 4'h7);
   wire ack_end = fall_ev & (bcnt_q == 4'h8);

   function automatic logic prot_hit(input logic [10:0] a, input logic [7:0] p);
      prot_hit = pre_s & ~p[`IEWS_PTR_FLAG_BIT] & (a >= {1'b1, pb_s, p[7:4], 4'h0});
   endfunction

   initial begin
      for (int i = 0; i < 2048; i++) begin
         mem[i] = 8'hff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers and edge history
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         meta_q <= 7'h7f;
         sync_q <= 7'h7f;
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
      end else begin
         meta_q <= {LINK.scl, LINK.sda, I_MODE_MULTI, I_WRITE_INHIBIT_PIN, I_PROTECT_EN,
                    I_PROTECT_BLOCK_SEL_HI, I_PROTECT_BLOCK_SEL_LO};
         sync_q <= meta_q;
         scl_d1_q <= sync_q[6];
         sda_d1_q <= sync_q[5];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit counting and shifting
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         bcnt_q <= 4'h0;
         rose_q <= 1'b0;
         shift_q <= 8'h00;
      end else if (start_ev | stop_ev) begin
         bcnt_q <= 4'h0;
         rose_q <= 1'b0;
      end else if (rise_ev) begin
         rose_q <= 1'b1;
         if (bcnt_q < 4'h8) begin
            shift_q <= {shift_q[6:0], sda_s};
         end
      end else if (fall_ev) begin
         rose_q <= 1'b0;
         bcnt_q <= ack_end ? 4'h0 : bcnt_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // acknowledge driver
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         sda_oe_n_q <= 1'b1;
      end else if (start_ev | stop_ev | ack_end | ~active) begin
         sda_oe_n_q <= 1'b1;
      end else if (byte_end) begin
         case (state_q)
            DS_DSEL: sda_oe_n_q <= ~(shift_q[7:4] == `IEWS_DEV_TYPE);
            DS_ADDR: sda_oe_n_q <= 1'b0;
            DS_DATA: sda_oe_n_q <= inhibit_q | wc_s;
            default: sda_oe_n_q <= 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command sequencing
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_q <= DS_IDLE;
         inhibit_q <= 1'b0;
         multi_q <= 1'b0;
         ptr_q <= 11'h000;
         count_q <= 5'h00;
         last_q <= 11'h000;
      end else if (start_ev) begin
         state_q <= DS_DSEL;
         inhibit_q <= wc_s;
         multi_q <= mode_s;
         count_q <= 5'h00;
      end else if (stop_ev) begin
         if ((state_q == DS_DATA) & (count_q != 5'h00) & ~inhibit_q) begin
            state_q <= DS_PROG;
         end else begin
            state_q <= DS_IDLE;
         end
      end else if (state_q == DS_PROG) begin
         if ((timer_q == 23'h0) & (pidx_q >= count_q)) begin
            state_q <= DS_IDLE;
         end
      end else begin
         if ((state_q == DS_DSEL) | (state_q == DS_ADDR)) begin
            inhibit_q <= inhibit_q | wc_s;
         end
         if (byte_end) begin
            case (state_q)
               DS_DSEL: begin
                  if (shift_q[7:4] != `IEWS_DEV_TYPE) begin
                     state_q <= DS_IDLE;
                  end else if (shift_q[0]) begin
                     state_q <= DS_READ;
                  end else begin
                     state_q <= DS_ADDR;
                     ptr_q[10:8] <= shift_q[3:1];
                  end
               end
               DS_ADDR: begin
                  state_q <= DS_DATA;
                  ptr_q[7:0] <= shift_q;
               end
               DS_DATA: begin
                  if (~inhibit_q & ~wc_s) begin
                     last_q <= ptr_q;
                     if (count_q < 5'(`IEWS_ROW_BYTES)) begin
                        count_q <= count_q + 5'h1;
                     end
                     if (multi_q) begin
                        ptr_q <= ptr_q + 11'h1;
                     end else begin
                        ptr_q[3:0] <= ptr_q[3:0] + 4'h1;
                     end
                  end
               end
               default: state_q <= state_q;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write latches; entries past a row all overwrite the first entry
   always_ff @(posedge I_SYS_CLK) begin
      if (byte_end & (state_q == DS_DATA) & ~inhibit_q & ~wc_s) begin
         buf_data[count_q[3:0]] <= shift_q;
         buf_addr[count_q[3:0]] <= ptr_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // programming timer and array update
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         timer_q <= 23'h0;
         pidx_q <= 5'h00;
         busy_q <= 1'b0;
      end else if (stop_ev & (state_q == DS_DATA) & (count_q != 5'h00) & ~inhibit_q) begin
         pidx_q <= 5'h00;
         busy_q <= 1'b1;
         if (buf_addr[0][10:4] != last_q[10:4]) begin
            timer_q <= 23'(2 * PROG_CYC - 1);
         end else begin
            timer_q <= 23'(PROG_CYC - 1);
         end
      end else if (state_q == DS_PROG) begin
         if (timer_q != 23'h0) begin
            timer_q <= timer_q - 23'h1;
         end
         if (pidx_q < count_q) begin
            pidx_q <= pidx_q + 5'h1;
         end
         busy_q <= (timer_q != 23'h0) | (pidx_q < count_q);
      end else begin
         busy_q <= 1'b0;
      end
   end

   wire [10:0] wr_addr = buf_addr[pidx_q[3:0]];
   // protection follows the start address, so a multibyte run may overrun the boundary
   wire wr_en = (state_q == DS_PROG) & (pidx_q < count_q) &
                ~prot_hit(buf_addr[0], mem[`IEWS_PTR_ADDR]);

   // plain always: the array also carries its erased power-up content
   always @(posedge I_SYS_CLK) begin
      if (wr_en) begin
         mem[wr_addr] <= buf_data[pidx_q[3:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_BUSY <= 1'b0;
      end else begin
         O_BUSY <= busy_q;
      end
   end

   assign LINK.d_sda_oe_n = sda_oe_n_q;
   assign LINK.d_sda_out = 1'b0;

endmodule

// file: src/iews_mst.sv
`include "iews_cfg.svh"
module iews_mst
   import iews_pkg::*;
#(
   parameter int QTR_CYC = `IEWS_QTR_CYC
) (
   // system
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   // avalon-mm slave
   input wire logic [3:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   // serial link
   iews_if.mst LINK
);

   ////////////////////////////////////////////////////////////////////////////
   iews_mst_state_t state_q;
   logic [1:0] ph_q;
   logic [9:0] div_q;
   logic [3:0] bit_q;
   logic [8:0] shift_q;
   logic go_bits_q;
   logic nack_q;
   logic scl_oe_n_q;
   logic sda_oe_n_q;
   logic meta_q;
   logic sda_s_q;

   wire tick = (div_q == 10'h0) & (state_q != MS_IDLE);
   wire take = I_AVS_WRITE & ~O_AVS_WAITREQUEST & (I_AVS_ADDRESS == `IEWS_REG_CMD) &
               (state_q == MS_IDLE);
   wire [1:0] op = I_AVS_WRITEDATA[`IEWS_CMD_OP_LSB +: 2];

   ////////////////////////////////////////////////////////////////////////////
   // register bus: one wait cycle, then the answer
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_AVS_WAITREQUEST <= 1'b1;
         O_AVS_READDATA <= 32'h0;
      end else if (O_AVS_WAITREQUEST & (I_AVS_READ | I_AVS_WRITE)) begin
         O_AVS_WAITREQUEST <= 1'b0;
         O_AVS_READDATA <= 32'h0;
         if (I_AVS_READ & (I_AVS_ADDRESS == `IEWS_REG_STATUS)) begin
            O_AVS_READDATA[`IEWS_ST_BUSY] <= state_q != MS_IDLE;
            O_AVS_READDATA[`IEWS_ST_NACK] <= nack_q;
         end
      end else begin
         O_AVS_WAITREQUEST <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data line synchroniser
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         meta_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         meta_q <= LINK.sda;
         sda_s_q <= meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // quarter period divider
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         div_q <= 10'h0;
      end else if (take | tick) begin
         div_q <= 10'(QTR_CYC - 1);
      end else if (div_q != 10'h0) begin
         div_q <= div_q - 10'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial sequencer; data changes while the clock is low, except for start and stop
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         state_q <= MS_IDLE;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         shift_q <= 9'h1ff;
         go_bits_q <= 1'b0;
         nack_q <= 1'b0;
         scl_oe_n_q <= 1'b1;
         sda_oe_n_q <= 1'b1;
      end else if (take) begin
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         shift_q <= {I_AVS_WRITEDATA[7:0], 1'b1};
         case (op)
            `IEWS_OP_START_BYTE: state_q <= MS_START;
            `IEWS_OP_BYTE: state_q <= MS_BITS;
            `IEWS_OP_STOP: state_q <= MS_STOP;
            default: state_q <= MS_IDLE;
         endcase
      end else if (tick) begin
         ph_q <= ph_q + 2'h1;
         case (state_q)
            MS_START: begin
               case (ph_q)
                  2'h0: sda_oe_n_q <= 1'b1;
                  2'h1: scl_oe_n_q <= 1'b1;
                  2'h2: sda_oe_n_q <= 1'b0;
                  default: begin
                     scl_oe_n_q <= 1'b0;
                     state_q <= MS_BITS;
                  end
               endcase
            end
            MS_BITS: begin
               case (ph_q)
                  2'h0: sda_oe_n_q <= shift_q[8];
                  2'h1: scl_oe_n_q <= 1'b1;
                  2'h2: begin
                     if (bit_q == 4'h8) begin
                        nack_q <= sda_s_q;
                     end
                  end
                  default: begin
                     scl_oe_n_q <= 1'b0;
                     shift_q <= {shift_q[7:0], 1'b1};
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h8) begin
                        state_q <= MS_IDLE;
                     end
                  end
               endcase
            end
            MS_STOP: begin
               case (ph_q)
                  2'h0: sda_oe_n_q <= 1'b0;
                  2'h1: scl_oe_n_q <= 1'b1;
                  2'h2: sda_oe_n_q <= 1'b1;
                  default: state_q <= MS_IDLE;
               endcase
            end
            default: state_q <= MS_IDLE;
         endcase
      end
   end

   assign LINK.scl_out = 1'b0;
   assign LINK.scl_oe_n = scl_oe_n_q;
   assign LINK.m_sda_out = 1'b0;
   assign LINK.m_sda_oe_n = sda_oe_n_q;

endmodule

// file: test/iews_link_sva.sv
module iews_link_chk #(
   parameter int ACK_CYC = 2000
) (
   // system
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   // link drivers and resolved lines
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic m_sda_out,
   input wire logic m_sda_oe_n,
   input wire logic d_sda_out,
   input wire logic d_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic scl_q, sda_q, in_frame_q;
   logic [3:0] bit_q;
   logic [11:0] low_q;
   logic [1:0] rise_q;
   wire start_w = scl_q & scl & sda_q & ~sda;
   wire stop_w = scl_q & scl & ~sda_q & sda;
   wire scl_up = ~scl_q & scl;
   default clocking @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   // frame flag and bit position within the current byte
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         in_frame_q <= 1'b0;
         bit_q <= 4'h0;
      end else begin
         in_frame_q <= start_w ? 1'b1 : (stop_w ? 1'b0 : in_frame_q);
         bit_q <= start_w ? 4'h0 : (scl_up ? ((bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1) : bit_q);
      end
   end
   // length of a device acknowledge and clock pulses inside it
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         low_q <= 12'h0;
         rise_q <= 2'h0;
      end else begin
         low_q <= d_sda_oe_n ? 12'h0 : low_q + 12'h1;
         rise_q <= d_sda_oe_n ? 2'h0 : rise_q + {1'b0, scl_up};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   chk_drive_zero: assert property ((scl_oe_n | !scl_out)
      && (m_sda_oe_n | !m_sda_out) && (d_sda_oe_n | !d_sda_out))
      else $error("a line driver pushes a high level");
   chk_data_stable: assert property ($rose(scl) |-> $stable(sda))
      else $error("data moved at a rising clock");
   chk_clk_in_frame: assert property ($fell(scl) |-> in_frame_q)
      else $error("clock pulsed outside a frame");
   chk_ack_ninth: assert property ($fell(d_sda_oe_n) |-> bit_q == 4'h8)
      else $error("acknowledge not after eight bits");
   chk_ack_width: assert property ($rose(d_sda_oe_n) |->
      low_q >= ACK_CYC - 10 && low_q <= ACK_CYC + 10)
      else $error("acknowledge not one bit long");
   chk_ack_one_pulse: assert property ($rose(d_sda_oe_n) |-> rise_q == 2'h1)
      else $error("acknowledge spans wrong clock count");
   chk_dev_drive_low: assert property ($fell(d_sda_oe_n) |-> !scl)
      else $error("device drives data while clock high");
   chk_dev_free_low: assert property ($rose(d_sda_oe_n) |-> !scl)
      else $error("device releases data while clock high");
   chk_mst_release: assert property ($rose(scl) && bit_q == 4'h8 |-> m_sda_oe_n)
      else $error("controller holds data in ninth bit");
   cov_start: cover property (start_w);
   cov_ack: cover property ($rose(d_sda_oe_n));
   cov_stop: cover property (stop_w);
endmodule

// file: test/test_i2c_eeprom_write_slave.sv
`include "iews_cfg.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_i2c_eeprom_write_slave;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PROG = 3000;
   localparam int QTR = 25;
   logic clk, rst, av_rd, av_wr, wreq, busy, mode, inhibit, pen, psl, psh;
   logic [3:0] av_adr;
   logic [31:0] av_wd, rdata;
   int error_cnt = 0;
   int n_checks = 0;
   int busy_cnt = 0;
   int busy_len = 0;
   iews_if i_iews_if ();
   iews_mst #(.QTR_CYC(QTR)) i_iews_mst (.I_SYS_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(av_adr),
      .I_AVS_READ(av_rd), .I_AVS_WRITE(av_wr), .I_AVS_WRITEDATA(av_wd),
      .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq), .LINK(i_iews_if.mst));
   iews_dev #(.PROG_CYC(PROG), .WC_VARIANT(1'b0)) i_iews_dev (.I_SYS_CLK(clk), .I_RST(rst),
      .LINK(i_iews_if.dev), .I_MODE_MULTI(mode), .I_WRITE_INHIBIT_PIN(inhibit),
      .I_PROTECT_EN(pen), .I_PROTECT_BLOCK_SEL_LO(psl), .I_PROTECT_BLOCK_SEL_HI(psh),
      .O_BUSY(busy));
   iews_link_chk #(.ACK_CYC(4 * QTR)) i_iews_link_chk (.I_SYS_CLK(clk), .I_RST(rst),
      .scl_out(i_iews_if.scl_out), .scl_oe_n(i_iews_if.scl_oe_n),
      .m_sda_out(i_iews_if.m_sda_out), .m_sda_oe_n(i_iews_if.m_sda_oe_n),
      .d_sda_out(i_iews_if.d_sda_out), .d_sda_oe_n(i_iews_if.d_sda_oe_n),
      .scl(i_iews_if.scl), .sda(i_iews_if.sda));
   always #2.5 clk = ~clk;
   // length of the last programming cycle
   always @(posedge clk) begin
      if (busy === 1'b1) begin
         busy_cnt <= busy_cnt + 1;
      end else if (busy_cnt != 0) begin
         busy_len <= busy_cnt;
         busy_cnt <= 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic fail_to;
      error_cnt++;
      $display("wrong value at %0t: wait ran out", $time);
      close_out();
   endtask
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      av_adr <= a;
      av_wd <= d;
      av_wr <= wr;
      av_rd <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      @(posedge clk);
      if (n >= 50) fail_to();
   endtask
   // one link operation, waiting for the controller to finish it
   task automatic send(input logic [1:0] code, input logic [7:0] b, input logic exp_nack);
      logic [31:0] q;
      int n;
      n = 0;
      av(1'b1, `IEWS_REG_CMD, {22'h0, code, b}, q);
      do begin
         av(1'b0, `IEWS_REG_STATUS, 32'h0, q);
         n++;
      end while (q[`IEWS_ST_BUSY] !== 1'b0 && n < 20000);
      if (n >= 20000) fail_to();
      if (code != `IEWS_OP_STOP) `CHK(q[`IEWS_ST_NACK], exp_nack)
   endtask
   function automatic logic [7:0] sel(input logic [2:0] blk, input logic rd);
      return {`IEWS_DEV_TYPE, blk, rd};
   endfunction
   task automatic wr_frame(input logic [2:0] blk, input logic [7:0] a, input int nb,
                           input logic [7:0] d);
      send(`IEWS_OP_START_BYTE, sel(blk, 1'b0), 1'b0);
      send(`IEWS_OP_BYTE, a, 1'b0);
      for (int i = 0; i < nb; i++) begin
         send(`IEWS_OP_BYTE, d + 8'(i), 1'b0);
      end
      send(`IEWS_OP_STOP, 8'h00, 1'b0);
      `CHK(busy, 1'b1)
   endtask
   task automatic wait_idle(input int exp);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 70000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 70000) fail_to();
      @(posedge clk);
      `CHK(busy_len >= exp - 1 && busy_len <= exp + 1, 1'b1)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] q;
      `CHK({busy, i_iews_if.scl, i_iews_if.sda}, 3'b011)
      av(1'b0, `IEWS_REG_STATUS, 32'h0, q);
      `CHK(q, 32'h0)
      av(1'b0, 4'h8, 32'h0, q);
      `CHK(q, 32'h0)
   endtask
   task automatic t_wrong_type;
      send(`IEWS_OP_START_BYTE, {~`IEWS_DEV_TYPE, 4'h0}, 1'b1);
      send(`IEWS_OP_STOP, 8'h00, 1'b0);
      `CHK(busy, 1'b0)
   endtask
   task automatic t_byte_poll;
      wr_frame(3'h7, 8'h20, 1, 8'h5a);
      send(`IEWS_OP_START_BYTE, sel(3'h7, 1'b0), 1'b1);
      send(`IEWS_OP_STOP, 8'h00, 1'b0);
      wait_idle(PROG);
      `CHK(i_iews_dev.mem[11'h720], 8'h5a)
      send(`IEWS_OP_START_BYTE, sel(3'h7, 1'b0), 1'b0);
      send(`IEWS_OP_STOP, 8'h00, 1'b0);
      repeat (10) @(posedge clk);
      `CHK(busy, 1'b0)
   endtask
   task automatic t_rows;
      mode <= 1'b1;
      pen <= 1'b1;
      wr_frame(3'h0, 8'h0f, 2, 8'h5a);
      wait_idle(2 * PROG);
      mode <= 1'b0;
      wr_frame(3'h0, 8'h0f, 2, 8'h5a);
      wait_idle(PROG);
      `CHK({i_iews_dev.mem[11'h000], i_iews_dev.mem[11'h010]}, 16'h5b5b)
   endtask
   task automatic t_protect;
      {mode, pen, psl, psh} <= 4'hf;
      wr_frame(3'h7, 8'hff, 1, 8'hf0);
      wait_idle(PROG);
      wr_frame(3'h7, 8'hef, 2, 8'h3c);
      wait_idle(2 * PROG);
      `CHK({i_iews_dev.mem[11'h7ef], i_iews_dev.mem[11'h7f0]}, 16'h3c3d)
      mode <= 1'b0;
      wr_frame(3'h7, 8'hf4, 1, 8'h11);
      wait_idle(PROG);
      `CHK(i_iews_dev.mem[11'h7f4], 8'hff)
   endtask
   task automatic t_read_sel;
      send(`IEWS_OP_START_BYTE, sel(3'h2, 1'b1), 1'b0);
      send(`IEWS_OP_STOP, 8'h00, 1'b0);
      repeat (10) @(posedge clk);
      `CHK(busy, 1'b0)
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {av_rd, av_wr, mode, inhibit, pen, psl, psh} = 7'h0;
      av_adr = 4'h0;
      av_wd = 32'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_wrong_type();
      t_byte_poll();
      t_rows();
      t_read_sel();
      t_protect();
      close_out();
   end
endmodule
